// >>> src/cbbsc_pkg.sv
// Constants, types and register map of the CAN bias control
package cbbsc_pkg;

   // Operating modes, set by software
   typedef enum logic [2:0] {
      CBBSC_MODE_NORMAL,
      CBBSC_MODE_SILENT,
      CBBSC_MODE_STANDBY,
      CBBSC_MODE_GO_TO_SLEEP,
      CBBSC_MODE_SLEEP
   } cbbsc_mode_t;

   // Bus bias states
   typedef enum logic [1:0] {
      CBBSC_BIAS_OFF,
      CBBSC_BIAS_AUTO_INACTIVE,
      CBBSC_BIAS_AUTO_ACTIVE,
      CBBSC_BIAS_ACTIVE
   } cbbsc_bias_t;

   // Bias level applied to the bus pins
   typedef enum logic [1:0] {
      CBBSC_LVL_FLOAT,
      CBBSC_LVL_GROUND,
      CBBSC_LVL_MID_2V5,
      CBBSC_LVL_HALF_CORE
   } cbbsc_level_t;

   // Supply indications from the analog comparators
   typedef struct packed {
      logic battery_undervoltage_falling;
      logic battery_undervoltage_rising;
      logic core_undervoltage_falling;
      logic core_undervoltage_rising;
      logic io_undervoltage_falling;
      logic io_undervoltage_rising;
   } cbbsc_supply_t;

   // Controls toward the bus driver and bias network
   typedef struct packed {
      logic         drive_dominant;
      cbbsc_level_t bias_level;
   } cbbsc_bus_ctl_t;

   // Register byte offsets
   localparam logic [3:0] CBBSC_REG_CTRL   = 4'h0;
   localparam logic [3:0] CBBSC_REG_STATUS = 4'h4;

   // Field positions
   localparam int CBBSC_CTRL_MODE_LSB  = 0;
   localparam int CBBSC_ST_BIAS_LSB    = 0;
   localparam int CBBSC_ST_CLAMP_BIT   = 2;
   localparam int CBBSC_ST_WAKE_BIT    = 3;
   localparam int CBBSC_ST_SILENT_BIT  = 4;
   localparam int CBBSC_ST_MODE_LSB    = 8;

   // Reset values
   localparam cbbsc_mode_t CBBSC_MODE_RST = CBBSC_MODE_STANDBY;
   localparam logic [31:0] CBBSC_RDATA_RST = 32'h0000_0000;

   // Clock rate and times in their own units
   localparam int CBBSC_CLK_MHZ          = 100;
   localparam int CBBSC_SILENCE_US       = 1000;
   localparam int CBBSC_WK_FILTER_NS     = 1000;
   localparam int CBBSC_WK_TIMEOUT_US    = 1000;

   // Cycle counts; filter is a least time, rounded up
   localparam int CBBSC_SILENCE_CYC = CBBSC_SILENCE_US * CBBSC_CLK_MHZ;
   localparam int CBBSC_WK_FILTER_CYC =
      (CBBSC_WK_FILTER_NS * CBBSC_CLK_MHZ + 999) / 1000;
   localparam int CBBSC_WK_TIMEOUT_CYC = CBBSC_WK_TIMEOUT_US * CBBSC_CLK_MHZ;

endpackage

// >>> src/cbbsc_core.sv
// CAN bus bias state control with Avalon-MM register slave
// Notes on behaviour
// - Bias logic holds exactly one of four states
// - Battery falling undervoltage forces off, bus floating
// - Battery above rising threshold: off to autonomous inactive
// - Autonomous inactive biases bus pins to ground
// - Remote wake: bias 2.5 V, autonomous active
// - Low power, silence timeout: back to inactive
// - Leaving normal/silent picks state by bus inactivity
// - Core/IO falling undervoltage: active to autonomous active
// - Active request under undervoltage: inactive to active-auto
// - Normal with good supplies enters active state
// - Normal or silent means active, half-core bias
// - Transmit low before leaving standby blocks transmitter
// - Normal: transmit low drives dominant, else release
// - Silent: driver off, receiver on
// - Standby and sleep: driver off, autonomous bias
// - Dominant bus maps to low transmit and receive
// - Normal/silent: receive high for recessive bus
// - Standby: receive high, low while wake pending
// - Sleep: receive high, tri-state without supplies
// - Wake detection disabled in normal and silent
// - Wake is dominant, recessive, dominant, each filtered
//
// Decided for this implementation: the register offsets and register access over Avalon-MM.
`timescale 1ns/1ps

module cbbsc_core #(
   parameter int SILENCE_CYC    = cbbsc_pkg::CBBSC_SILENCE_CYC,
   parameter int WK_FILTER_CYC  = cbbsc_pkg::CBBSC_WK_FILTER_CYC,
   parameter int WK_TIMEOUT_CYC = cbbsc_pkg::CBBSC_WK_TIMEOUT_CYC
) (
   input  wire logic                      core_clk_i,     // System clock
   input  wire logic                      srst_i,         // Sync reset
   // Avalon-MM slave
   input  wire logic [3:0]                avs_address_i,  // Byte address
   input  wire logic                      avs_read_i,     // Read request
   input  wire logic                      avs_write_i,    // Write request
   input  wire logic [31:0]               avs_writedata_i,// Write data
   input  wire logic [3:0]                avs_byteenable_i,// Byte lanes
   output logic [31:0]                    avs_readdata_o, // Read data
   output logic                           avs_waitrequest_o,// Stall
   // Pins and analog indications
   input  wire logic                      txd_i,          // Transmit, low=dom
   input  wire logic                      bus_dominant_i, // Bus comparator
   input  wire cbbsc_pkg::cbbsc_supply_t  supply_i,       // Supply flags
   output logic                           rxd_o,          // Receive, low=dom
   output logic                           rxd_oe_o,       // Receive enable
   output cbbsc_pkg::cbbsc_bus_ctl_t      bus_ctl_o,      // Driver and bias
   output cbbsc_pkg::cbbsc_bias_t         bias_state_o,   // Bias state
   output logic                           transmit_clamp_fault_o // Clamp
);
   import cbbsc_pkg::*;
   localparam int SW = $clog2(SILENCE_CYC + 1);
   localparam int FW = $clog2(WK_FILTER_CYC + 1);
   localparam int TW = $clog2(WK_TIMEOUT_CYC + 1);
   localparam int NIN = 8;
   // Wake pattern detector states
   typedef enum logic [1:0] {
      WK_IDLE,
      WK_WAIT_REC,
      WK_WAIT_DOM
   } cbbsc_wk_t;
   // Three-stage synchronisers for every asynchronous input
   logic [NIN-1:0] async_in;
   logic [NIN-1:0] sync1_ff;
   logic [NIN-1:0] sync2_ff;
   logic [NIN-1:0] sync3_ff;
   logic [NIN-1:0] clean_ff;
   assign async_in = {txd_i, bus_dominant_i, supply_i};
   // Stage one feeds stage two only
   always_ff @(posedge core_clk_i) begin
      if (srst_i) begin
         sync1_ff <= '0;
         sync2_ff <= '0;
         sync3_ff <= '0;
      end else begin
         sync1_ff <= async_in;
         sync2_ff <= sync1_ff;
         sync3_ff <= sync2_ff;
      end
   end

   // A change counts only once stages two and three agree
   genvar gi;
   generate
      for (gi = 0; gi < NIN; gi++) begin : g_agree
         always_ff @(posedge core_clk_i) begin
            if (srst_i) begin
               clean_ff[gi] <= (gi == NIN - 1);
            end else if (sync2_ff[gi] == sync3_ff[gi]) begin
               clean_ff[gi] <= sync3_ff[gi];
            end
         end
      end
   endgenerate
   cbbsc_supply_t sup;
   logic          txd_s;
   logic          dom_s;
   assign sup   = clean_ff[5:0];
   assign dom_s = clean_ff[6];
   assign txd_s = clean_ff[7];
   // Supply summaries
   logic cio_fail;
   logic cio_good;
   assign cio_fail = sup.core_undervoltage_falling
                   | sup.io_undervoltage_falling;
   assign cio_good = sup.core_undervoltage_rising
                   & sup.io_undervoltage_rising & ~cio_fail;
   // Register state
   cbbsc_mode_t mode_ff;
   logic        ack_ff;
   logic [31:0] rdata_ff;
   logic        req;
   logic        wr_ok;
   assign req               = avs_read_i | avs_write_i;
   assign avs_waitrequest_o = req & ~ack_ff;
   assign avs_readdata_o    = rdata_ff;
   assign wr_ok = avs_write_i & ack_ff & (avs_address_i == CBBSC_REG_CTRL)
                & avs_byteenable_i[0];
   logic act_req;
   logic low_pwr;
   assign act_req = (mode_ff == CBBSC_MODE_NORMAL)
                  | (mode_ff == CBBSC_MODE_SILENT);
   assign low_pwr = ~act_req;
   // One wait state per access; the acknowledge lasts one cycle
   always_ff @(posedge core_clk_i) begin
      if (srst_i) begin
         ack_ff <= 1'b0;
      end else begin
         ack_ff <= req & ~ack_ff;
      end
   end
   // Mode register; unknown encodings are ignored
   logic [2:0] wr_mode;
   assign wr_mode = avs_writedata_i[CBBSC_CTRL_MODE_LSB +: 3];
   always_ff @(posedge core_clk_i) begin
      if (srst_i) begin
         mode_ff <= CBBSC_MODE_RST;
      end else if (wr_ok && wr_mode <= 3'(CBBSC_MODE_SLEEP)) begin
         mode_ff <= cbbsc_mode_t'(wr_mode);
      end
   end
   // Silence timer, restarted on bus change, saturating
   logic          dom_d_ff;
   logic [SW-1:0] sil_cnt_ff;
   logic          silence_expired;
   always_ff @(posedge core_clk_i) begin
      if (srst_i) begin
         dom_d_ff   <= 1'b0;
         sil_cnt_ff <= '0;
      end else begin
         dom_d_ff <= dom_s;
         if (dom_s != dom_d_ff) begin
            sil_cnt_ff <= '0;
         end else if (!silence_expired) begin
            sil_cnt_ff <= sil_cnt_ff + 1'b1;
         end
      end
   end
   assign silence_expired = (sil_cnt_ff >= SW'(SILENCE_CYC));
   // Wake filter: bus level held for the filter time
   logic [FW-1:0] flt_cnt_ff;
   logic          filt_dom;
   logic          filt_rec;
   always_ff @(posedge core_clk_i) begin
      if (srst_i) begin
         flt_cnt_ff <= '0;
      end else if (dom_s != dom_d_ff) begin
         flt_cnt_ff <= '0;
      end else if (flt_cnt_ff < FW'(WK_FILTER_CYC)) begin
         flt_cnt_ff <= flt_cnt_ff + 1'b1;
      end
   end
   assign filt_dom = (flt_cnt_ff >= FW'(WK_FILTER_CYC)) & dom_s;
   assign filt_rec = (flt_cnt_ff >= FW'(WK_FILTER_CYC)) & ~dom_s;
   // Wake pattern sequencer with overall timeout
   cbbsc_wk_t     wk_ff;
   logic [TW-1:0] wk_tmo_ff;
   logic          wake_det;
   logic          wk_expired;
   assign wk_expired = (wk_tmo_ff >= TW'(WK_TIMEOUT_CYC));
   always_ff @(posedge core_clk_i) begin
      if (srst_i || act_req) begin
         wk_ff     <= WK_IDLE;
         wk_tmo_ff <= '0;
      end else begin
         case (wk_ff)
            WK_IDLE: begin
               wk_tmo_ff <= '0;
               if (filt_dom) begin
                  wk_ff <= WK_WAIT_REC;
               end
            end
            WK_WAIT_REC: begin
               wk_tmo_ff <= wk_tmo_ff + 1'b1;
               if (wk_expired) begin
                  wk_ff <= WK_IDLE;
               end else if (filt_rec) begin
                  wk_ff <= WK_WAIT_DOM;
               end
            end
            WK_WAIT_DOM: begin
               wk_tmo_ff <= wk_tmo_ff + 1'b1;
               if (wk_expired || filt_dom) begin
                  wk_ff <= WK_IDLE;
               end
            end
            default: wk_ff <= WK_IDLE;
         endcase
      end
   end
   // Fires once on the second filtered dominant in time
   assign wake_det = (wk_ff == WK_WAIT_DOM) & filt_dom & ~wk_expired
                   & low_pwr;
   // Pending wake, kept until normal mode clears it
   logic wake_pending_ff;
   always_ff @(posedge core_clk_i) begin
      if (srst_i) begin
         wake_pending_ff <= 1'b0;
      end else if (wake_det) begin
         wake_pending_ff <= 1'b1;
      end else if (mode_ff == CBBSC_MODE_NORMAL) begin
         wake_pending_ff <= 1'b0;
      end
   end
   // Bias state machine
   cbbsc_bias_t bias_ff;
   cbbsc_bias_t nxt_bias;
   always_comb begin
      nxt_bias = bias_ff;
      if (sup.battery_undervoltage_falling) begin
         nxt_bias = CBBSC_BIAS_OFF;
      end else begin
         case (bias_ff)
            CBBSC_BIAS_OFF: begin
               if (sup.battery_undervoltage_rising) begin
                  nxt_bias = CBBSC_BIAS_AUTO_INACTIVE;
               end
            end
            CBBSC_BIAS_AUTO_INACTIVE: begin
               if (act_req && cio_fail) begin
                  nxt_bias = CBBSC_BIAS_AUTO_ACTIVE;
               end else if (act_req && cio_good) begin
                  nxt_bias = CBBSC_BIAS_ACTIVE;
               end else if (wake_det) begin
                  nxt_bias = CBBSC_BIAS_AUTO_ACTIVE;
               end
            end
            CBBSC_BIAS_AUTO_ACTIVE: begin
               if (act_req && cio_good) begin
                  nxt_bias = CBBSC_BIAS_ACTIVE;
               end else if (low_pwr && silence_expired) begin
                  nxt_bias = CBBSC_BIAS_AUTO_INACTIVE;
               end
            end
            CBBSC_BIAS_ACTIVE: begin
               if (cio_fail) begin
                  nxt_bias = CBBSC_BIAS_AUTO_ACTIVE;
               end else if (low_pwr && silence_expired) begin
                  nxt_bias = CBBSC_BIAS_AUTO_INACTIVE;
               end else if (low_pwr) begin
                  nxt_bias = CBBSC_BIAS_AUTO_ACTIVE;
               end
            end
            default: nxt_bias = CBBSC_BIAS_OFF;
         endcase
      end
   end
   // Single state register keeps the four states exclusive
   always_ff @(posedge core_clk_i) begin
      if (srst_i) begin
         bias_ff <= CBBSC_BIAS_OFF;
      end else begin
         bias_ff <= nxt_bias;
      end
   end
   // Clamp: transmit low on entering active blocks the driver
   logic clamp_ff;
   logic enter_act;
   assign enter_act = (nxt_bias == CBBSC_BIAS_ACTIVE)
                    & (bias_ff != CBBSC_BIAS_ACTIVE);
   always_ff @(posedge core_clk_i) begin
      if (srst_i) begin
         clamp_ff <= 1'b0;
      end else if (enter_act && !txd_s) begin
         clamp_ff <= 1'b1;
      end else if (txd_s || bias_ff != CBBSC_BIAS_ACTIVE) begin
         clamp_ff <= 1'b0; // Released once transmit returns high
      end
   end
   // Driver and bias; registered so pins never glitch
   logic         nxt_drive;
   cbbsc_level_t nxt_level;
   always_comb begin
      nxt_drive = (bias_ff == CBBSC_BIAS_ACTIVE)
                & (mode_ff == CBBSC_MODE_NORMAL)
                & ~clamp_ff & ~txd_s;
      case (bias_ff)
         CBBSC_BIAS_OFF:           nxt_level = CBBSC_LVL_FLOAT;
         CBBSC_BIAS_AUTO_INACTIVE: nxt_level = CBBSC_LVL_GROUND;
         CBBSC_BIAS_AUTO_ACTIVE:   nxt_level = CBBSC_LVL_MID_2V5;
         CBBSC_BIAS_ACTIVE:        nxt_level = CBBSC_LVL_HALF_CORE;
         default:                  nxt_level = CBBSC_LVL_FLOAT;
      endcase
   end
   // Receive pin per mode
   logic nxt_rxd;
   logic nxt_rxd_oe;
   always_comb begin
      nxt_rxd    = 1'b1;
      nxt_rxd_oe = 1'b1;
      case (mode_ff)
         CBBSC_MODE_NORMAL, CBBSC_MODE_SILENT: begin
            nxt_rxd = ~dom_s;
         end
         CBBSC_MODE_STANDBY: begin
            nxt_rxd = ~wake_pending_ff;
         end
         CBBSC_MODE_GO_TO_SLEEP, CBBSC_MODE_SLEEP: begin
            nxt_rxd_oe = ~sup.io_undervoltage_falling
                       & ~sup.battery_undervoltage_falling;
         end
         default: nxt_rxd = 1'b1;
      endcase
   end
   // Output flops
   always_ff @(posedge core_clk_i) begin
      if (srst_i) begin
         bus_ctl_o <= '{drive_dominant: 1'b0, bias_level: CBBSC_LVL_FLOAT};
         rxd_o     <= 1'b1;
         rxd_oe_o  <= 1'b0;
      end else begin
         bus_ctl_o.drive_dominant <= nxt_drive;
         bus_ctl_o.bias_level     <= nxt_level;
         rxd_o                    <= nxt_rxd;
         rxd_oe_o                 <= nxt_rxd_oe;
      end
   end

   assign bias_state_o           = bias_ff;
   assign transmit_clamp_fault_o = clamp_ff;

   // Read data captured in the wait cycle, stands at the ack edge
   logic [31:0] nxt_rdata;
   always_comb begin
      nxt_rdata = CBBSC_RDATA_RST;
      case (avs_address_i)
         CBBSC_REG_CTRL: nxt_rdata[CBBSC_CTRL_MODE_LSB +: 3] = mode_ff;
         CBBSC_REG_STATUS: begin
            nxt_rdata[CBBSC_ST_BIAS_LSB +: 2] = bias_ff;
            nxt_rdata[CBBSC_ST_CLAMP_BIT]     = clamp_ff;
            nxt_rdata[CBBSC_ST_WAKE_BIT]      = wake_pending_ff;
            nxt_rdata[CBBSC_ST_SILENT_BIT]    = silence_expired;
            nxt_rdata[CBBSC_ST_MODE_LSB +: 3] = mode_ff;
         end
         default: nxt_rdata = CBBSC_RDATA_RST; // Unmapped reads zero
      endcase
   end

   always_ff @(posedge core_clk_i) begin
      if (srst_i) begin
         rdata_ff <= CBBSC_RDATA_RST;
      end else if (avs_read_i && !ack_ff) begin
         rdata_ff <= nxt_rdata;
      end
   end

endmodule

// >>> test/cbbsc_monitor.sv
// Assertion checker for the CAN bias state control ports
`timescale 1ns/1ps

module cbbsc_monitor (
   input  wire logic                     core_clk_i,        // Clock
   input  wire logic                     srst_i,            // Sync reset
   input  wire logic                     avs_read_i,        // Read request
   input  wire logic                     avs_write_i,       // Write request
   input  wire logic                     avs_waitrequest_o, // Stall
   input  wire logic                     txd_i,             // Transmit pin
   input  wire logic                     bus_dominant_i,    // Bus comparator
   input  wire cbbsc_pkg::cbbsc_supply_t supply_i,          // Supply flags
   input  wire logic                     rxd_o,             // Receive pin
   input  wire cbbsc_pkg::cbbsc_bus_ctl_t bus_ctl_o,        // Driver, bias
   input  wire cbbsc_pkg::cbbsc_bias_t   bias_state_o,      // Bias state
   input  wire logic                     transmit_clamp_fault_o // Clamp
);
   import cbbsc_pkg::*;

   default clocking @(posedge core_clk_i); endclocking
   default disable iff (srst_i);

   // Multi-cycle steps
   sequence s_leave_off;
      bias_state_o == CBBSC_BIAS_OFF ##1 bias_state_o != CBBSC_BIAS_OFF;
   endsequence
   sequence s_access;
      $rose(avs_read_i || avs_write_i);
   endsequence

   // Bias state and bus level; ctl lags one edge
   a_batfail_to_off: assert property (supply_i.battery_undervoltage_falling [*8]
      |-> bias_state_o == CBBSC_BIAS_OFF) else $error("no off on battery");
   a_off_floats: assert property (bias_state_o == CBBSC_BIAS_OFF [*2]
      |-> bus_ctl_o == 3'h0) else $error("off state not floating");
   a_off_exit_inact: assert property (s_leave_off
      |-> bias_state_o == CBBSC_BIAS_AUTO_INACTIVE) else $error("bad exit");
   a_inact_ground: assert property (bias_state_o == CBBSC_BIAS_AUTO_INACTIVE [*2]
      |-> bus_ctl_o.bias_level == CBBSC_LVL_GROUND) else $error("no ground");
   a_autoact_mid: assert property (bias_state_o == CBBSC_BIAS_AUTO_ACTIVE [*2]
      |-> bus_ctl_o.bias_level == CBBSC_LVL_MID_2V5) else $error("no mid");
   a_active_half: assert property (bias_state_o == CBBSC_BIAS_ACTIVE [*2]
      |-> bus_ctl_o.bias_level == CBBSC_LVL_HALF_CORE) else $error("no half");
   // Driver only when active, never for high or clamped txd
   a_drive_active: assert property (bus_ctl_o.drive_dominant
      |-> bias_state_o == CBBSC_BIAS_ACTIVE
          || $past(bias_state_o) == CBBSC_BIAS_ACTIVE) else $error("drive");
   a_quiet_txd: assert property (txd_i [*8] |-> !bus_ctl_o.drive_dominant)
      else $error("drive with txd high");
   a_clamp_nodrive: assert property (transmit_clamp_fault_o [*2]
      |-> !bus_ctl_o.drive_dominant) else $error("clamped but driving");
   a_clamp_active: assert property ((bias_state_o != CBBSC_BIAS_ACTIVE) [*2]
      |-> !transmit_clamp_fault_o) else $error("clamp outside active");
   // Receive follows bus when active
   a_rxd_recessive: assert property
      ((bias_state_o == CBBSC_BIAS_ACTIVE && !bus_dominant_i) [*8] |-> rxd_o)
      else $error("rxd low on recessive bus");
   a_rxd_dominant: assert property
      ((bias_state_o == CBBSC_BIAS_ACTIVE && bus_dominant_i) [*8] |-> !rxd_o)
      else $error("rxd high on dominant bus");
   // One wait state per access
   a_one_wait: assert property (s_access
      |-> avs_waitrequest_o ##1 !avs_waitrequest_o) else $error("wait count");
endmodule

bind cbbsc_core cbbsc_monitor u_mon (.core_clk_i, .srst_i, .avs_read_i,
   .avs_write_i, .avs_waitrequest_o, .txd_i, .bus_dominant_i, .supply_i,
   .rxd_o, .bus_ctl_o, .bias_state_o, .transmit_clamp_fault_o);

// >>> test/cbbsc_can_partner.sv
// Behavioural CAN controller and bus model for the bias control bench
`timescale 1ns/1ps

module cbbsc_can_partner (
   input  wire logic       clk_i,          // Clock
   input  wire logic       srst_i,         // Sync reset
   input  wire logic       wake_go_i,      // Start a wake pattern
   input  wire logic [7:0] wake_len_i,     // Cycles per pattern phase
   input  wire logic       dom_req_i,      // Another node drives dominant
   input  wire logic       txd_req_i,      // Controller transmit level
   output logic            txd_o,          // Transmit pin, low=dominant
   output logic            bus_dominant_o, // Bus comparator, high=dominant
   output logic            busy_o          // Pattern in progress
);
   logic [1:0] phase_ff;
   logic [7:0] cnt_ff;

   // Dominant, recessive, dominant; short phases test the filter
   always_ff @(posedge clk_i) begin
      if (srst_i) begin
         phase_ff <= 2'h0;
         cnt_ff   <= 8'h00;
      end else if (phase_ff == 2'h0) begin
         phase_ff <= wake_go_i ? 2'h1 : 2'h0;
         cnt_ff   <= 8'h00;
      end else if (cnt_ff == wake_len_i - 8'h01) begin
         phase_ff <= (phase_ff == 2'h3) ? 2'h0 : phase_ff + 2'h1;
         cnt_ff   <= 8'h00;
      end else begin
         cnt_ff <= cnt_ff + 8'h01;
      end
   end

   // The controller always drives transmit; low asks for dominant
   assign txd_o          = txd_req_i;
   assign bus_dominant_o = dom_req_i | phase_ff[0];
   assign busy_o         = phase_ff != 2'h0;
endmodule

// >>> test/cbbsc_core_tb.sv
// Self-checking bench for the CAN bias state control
`timescale 1ns/1ps

module cbbsc_core_tb;
   import cbbsc_pkg::*;
   localparam logic [5:0] GOOD = 6'h15;
   localparam logic [5:0] CORE_LO = 6'h19;
   localparam logic [5:0] IO_LO = 6'h16;
   localparam logic [5:0] BAT_LO = 6'h20;
   localparam cbbsc_bias_t B_INA = CBBSC_BIAS_AUTO_INACTIVE;
   localparam cbbsc_bias_t B_AAC = CBBSC_BIAS_AUTO_ACTIVE;
   localparam cbbsc_bias_t B_ACT = CBBSC_BIAS_ACTIVE;
   logic           core_clk_i, srst_i, avs_read_i, avs_write_i;
   logic [3:0]     avs_address_i, avs_byteenable_i;
   logic [31:0]    avs_writedata_i, avs_readdata_o, rd_q;
   logic           avs_waitrequest_o, txd_i, bus_dominant_i;
   logic           rxd_o, rxd_oe_o, transmit_clamp_fault_o;
   logic           wake_go, dom_req, txd_req, wake_busy;
   logic [7:0]     wake_len;
   cbbsc_supply_t  supply_i;
   cbbsc_bus_ctl_t bus_ctl_o;
   cbbsc_bias_t    bias_state_o;
   int             error_cnt, total_checks;

   // Short counts keep the run brief
   cbbsc_core #(.SILENCE_CYC(200), .WK_FILTER_CYC(4), .WK_TIMEOUT_CYC(300))
   DUT (.core_clk_i, .srst_i, .avs_address_i, .avs_read_i, .avs_write_i,
      .avs_writedata_i, .avs_byteenable_i, .avs_readdata_o,
      .avs_waitrequest_o, .txd_i, .bus_dominant_i, .supply_i, .rxd_o,
      .rxd_oe_o, .bus_ctl_o, .bias_state_o, .transmit_clamp_fault_o);

   cbbsc_can_partner u_far (.clk_i(core_clk_i), .srst_i(srst_i),
      .wake_go_i(wake_go), .wake_len_i(wake_len), .dom_req_i(dom_req),
      .txd_req_i(txd_req), .txd_o(txd_i), .bus_dominant_o(bus_dominant_i),
      .busy_o(wake_busy));

   // 100 MHz clock
   initial begin
      core_clk_i = 1'b0;
      forever #5 core_clk_i = ~core_clk_i;
   end

   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      total_checks++;
      if (got !== exp) begin
         error_cnt++;
         $display("BAD t=%0t got %h expected %h", $time, got, exp);
      end
   endtask

   task automatic close_out();
      $display("checks %0d mismatches %0d", total_checks, error_cnt);
      if (error_cnt == 0 && total_checks > 0) begin
         $display("ALL TESTS PASSED");
      end else begin
         $display("TESTS FAILED");
      end
      $finish;
   endtask

   task automatic hang();
      error_cnt++;
      $display("BAD t=%0t wait ran out", $time);
      close_out();
   endtask

   task automatic tdone(input string s);
      $display("test %s done, mismatches %0d", s, error_cnt);
   endtask

   // Request holds up to the edge that samples waitrequest low
   task automatic av(input logic w, input logic [3:0] a, input logic [31:0] d);
      int n;
      @(posedge core_clk_i);
      avs_address_i   <= a;
      avs_writedata_i <= d;
      avs_write_i     <= w;
      avs_read_i      <= ~w;
      for (n = 0; n < 20; n++) begin
         @(posedge core_clk_i);
         if (avs_waitrequest_o === 1'b0) break;
      end
      if (n == 20) hang();
      rd_q = avs_readdata_o;
      avs_write_i <= 1'b0;
      avs_read_i  <= 1'b0;
      @(negedge core_clk_i);
   endtask

   task automatic rchk(input logic [3:0] a, input logic [31:0] m,
                       input logic [31:0] e);
      av(1'b0, a, 32'h0);
      chk(rd_q & m, e);
   endtask

   task automatic set_mode(input cbbsc_mode_t m);
      av(1'b1, CBBSC_REG_CTRL, 32'(m));
   endtask

   // Pins change at a rising edge; checks run at the falling edge
   task automatic pins(input logic [5:0] s, input logic t, input logic d);
      @(posedge core_clk_i);
      supply_i <= s;
      txd_req  <= t;
      dom_req  <= d;
   endtask

   task automatic step(input int n);
      repeat (n) @(posedge core_clk_i);
      @(negedge core_clk_i);
   endtask

   task automatic wbias(input cbbsc_bias_t e, input int b);
      int n;
      for (n = 0; n < b && bias_state_o !== e; n++) @(negedge core_clk_i);
      if (n == b) hang();
      chk(32'(bias_state_o), 32'(e));
   endtask

   task automatic wake(input logic [7:0] len);
      int n;
      @(posedge core_clk_i);
      wake_len <= len;
      wake_go  <= 1'b1;
      @(posedge core_clk_i);
      wake_go <= 1'b0;
      @(negedge core_clk_i);
      for (n = 0; n < 100 && wake_busy === 1'b1; n++) @(negedge core_clk_i);
      if (n == 100) hang();
   endtask

   // Main sequence; 8-cycle settles cover sync and output stages
   initial begin
      srst_i = 1'b1;
      {avs_read_i, avs_write_i, wake_go, dom_req} = 4'h0;
      avs_address_i = 4'h0;
      avs_writedata_i = 32'h0;
      avs_byteenable_i = 4'hF;
      supply_i = BAT_LO;
      txd_req = 1'b1;
      wake_len = 8'h08;
      error_cnt = 0;
      total_checks = 0;
      repeat (6) @(posedge core_clk_i);
      srst_i <= 1'b0;
      step(1);
      chk(32'(bias_state_o), 32'(CBBSC_BIAS_OFF));
      chk(32'(bus_ctl_o), 32'h0);
      rchk(CBBSC_REG_STATUS, 32'h703, 32'h200);
      tdone("reset");
      pins(GOOD, 1'b1, 1'b0);
      wbias(B_INA, 20);
      step(2);
      chk(32'(bus_ctl_o), 32'(CBBSC_LVL_GROUND));
      wake(8'h02);
      step(10);
      chk(32'(bias_state_o), 32'(B_INA));
      wake(8'h08);
      wbias(B_AAC, 20);
      step(2);
      chk(32'(bus_ctl_o), 32'(CBBSC_LVL_MID_2V5));
      chk(32'(rxd_o), 32'h0);
      rchk(CBBSC_REG_STATUS, 32'h8, 32'h8);
      wbias(B_INA, 400);
      tdone("wake");
      pins(CORE_LO, 1'b1, 1'b0);
      step(8);
      set_mode(CBBSC_MODE_NORMAL);
      wbias(B_AAC, 20);
      pins(GOOD, 1'b1, 1'b0);
      set_mode(CBBSC_MODE_STANDBY);
      set_mode(CBBSC_MODE_NORMAL);
      wbias(B_ACT, 20);
      step(2);
      chk(32'(bus_ctl_o), 32'(CBBSC_LVL_HALF_CORE));
      rchk(CBBSC_REG_STATUS, 32'h8, 32'h0);
      pins(GOOD, 1'b0, 1'b0);
      step(8);
      chk(32'(bus_ctl_o.drive_dominant), 32'h1);
      pins(GOOD, 1'b1, 1'b1);
      step(8);
      chk(32'(bus_ctl_o.drive_dominant), 32'h0);
      chk(32'(rxd_o), 32'h0);
      pins(GOOD, 1'b1, 1'b0);
      step(8);
      chk(32'(rxd_o), 32'h1);
      wake(8'h08);
      rchk(CBBSC_REG_STATUS, 32'h8, 32'h0);
      tdone("normal");
      set_mode(CBBSC_MODE_SILENT);
      pins(GOOD, 1'b0, 1'b1);
      step(8);
      chk(32'(bus_ctl_o.drive_dominant), 32'h0);
      chk(32'(rxd_o), 32'h0);
      chk(32'(bias_state_o), 32'(B_ACT));
      for (int i = 0; i < 2; i++) begin
         pins((i == 0) ? CORE_LO : IO_LO, 1'b1, 1'b0);
         wbias(B_AAC, 20);
         pins(GOOD, 1'b1, 1'b0);
         set_mode(CBBSC_MODE_STANDBY);
         set_mode(CBBSC_MODE_NORMAL);
         wbias(B_ACT, 20);
      end
      tdone("silent_supply");
      pins(GOOD, 1'b1, 1'b1);
      step(8);
      pins(GOOD, 1'b1, 1'b0);
      step(8);
      set_mode(CBBSC_MODE_GO_TO_SLEEP);
      wbias(B_AAC, 20);
      chk(32'(rxd_o), 32'h1);
      wbias(B_INA, 400);
      set_mode(CBBSC_MODE_NORMAL);
      wbias(B_ACT, 20);
      step(250);
      set_mode(CBBSC_MODE_SLEEP);
      wbias(B_INA, 20);
      pins(IO_LO, 1'b1, 1'b0);
      step(8);
      chk(32'(rxd_oe_o), 32'h0);
      tdone("low_power");
      set_mode(CBBSC_MODE_STANDBY);
      pins(GOOD, 1'b0, 1'b0);
      step(8);
      set_mode(CBBSC_MODE_NORMAL);
      wbias(B_ACT, 20);
      step(2);
      chk(32'(transmit_clamp_fault_o), 32'h1);
      chk(32'(bus_ctl_o.drive_dominant), 32'h0);
      pins(GOOD, 1'b1, 1'b0);
      step(8);
      chk(32'(transmit_clamp_fault_o), 32'h0);
      tdone("clamp");
      av(1'b1, CBBSC_REG_CTRL, 32'h7);
      av(1'b1, CBBSC_REG_STATUS, 32'hFFFF_FFFF);
      rchk(CBBSC_REG_STATUS, 32'h703, 32'(B_ACT));
      rchk(4'h8, 32'hFFFF_FFFF, 32'h0);
      tdone("registers");
      pins(BAT_LO, 1'b1, 1'b0);
      wbias(CBBSC_BIAS_OFF, 20);
      step(2);
      chk(32'(bus_ctl_o), 32'h0);
      tdone("battery");
      close_out();
   end
endmodule
